//--- verilog/ssrs_pkg.sv
// package: constants of the staged reset release sequencer
package ssrs_pkg;

  // ---------------------------------------------------------------
  // release counts, in ticks of the clock that times each stage
  // ---------------------------------------------------------------
  localparam int unsigned POR_STRETCH_TICKS = 64; // oscillator
  localparam int unsigned SYNC_LOGIC_TICKS = 3;   // oscillator
  localparam int unsigned CLKGEN_TICKS = 32;      // oscillator
  localparam int unsigned PERIPH_TICKS = 32;      // system clock
  localparam int unsigned CORE_TICKS = 32;        // system clock

  // ---------------------------------------------------------------
  // clock dividers, in cycles of the 250 MHz block clock
  // ---------------------------------------------------------------
  localparam int unsigned OSC_DIV_DEF = 32; // about 8 MHz oscillator
  localparam int unsigned SYS_DIV_DEF = 8;  // about 31 MHz system
  localparam int unsigned DIV_W = 8;
  localparam int unsigned DIV_MAX = 256;

  // ---------------------------------------------------------------
  // pin synchroniser depth and reset values
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_DEPTH = 3;
  localparam logic [SYNC_DEPTH-1:0] SYNC_RST = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;

endpackage : ssrs_pkg

//--- verilog/ssrs_extender.sv
// file: one reset extender, releasing a set number of ticks late
`timescale 1ns/100ps
module ssrs_extender #(
  parameter int unsigned COUNT = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // upstream reset and time base
  input wire logic hold,
  input wire logic tick,
  // stretched reset
  output logic rst_out_q
);

  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
  localparam logic [CW-1:0] FULL = CW'(COUNT);

  logic [CW-1:0] cnt_q;

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (COUNT < 1) begin : g_bad_count
    $error("extender count must be at least one");
  end

  // ---------------------------------------------------------------
  // tick counter, cleared whenever upstream reset reasserts
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (hold) begin
      cnt_q <= '0;
    end else if (tick && cnt_q != FULL) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // release only on a tick, so it lands on the chosen clock edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_out_q <= 1'b1;
    end else if (hold) begin
      rst_out_q <= 1'b1;
    end else if (tick && cnt_q == LAST) begin
      rst_out_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ext_hold_a: assert property (@(posedge clk) disable iff (rst)
    hold |=> rst_out_q)
    else $error("extender released while upstream held");

  ext_count_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst_out_q) |-> $past(tick) && $past(cnt_q) == LAST)
    else $error("extender released at wrong count");

endmodule : ssrs_extender

//--- verilog/ssrs_sequencer.sv
// file: staged reset release sequencer, top level
//
// Behaviour
// - Pin and power-on resets are asynchronous; software and watchdog synchronous.
// - Stretched power-on reset releases 64 oscillator cycles after power-on.
// - Combined reset ORs all sources and holds everything but the stretcher and test logic reset.
// - Control, sync reset generator, clock-gen stretcher run after combined.
// - Software and watchdog logic stay reset three oscillator cycles longer.
// - Clock generation reset releases 32 oscillator cycles after combined.
// - Clock generation and peripheral stretcher run once clock-gen released.
// - Peripheral reset releases 32 system cycles after clock-gen reset.
// - Processor reset releases 32 system cycles after peripheral reset.
// - Code runs only once processor reset releases; sequence ends there.
// - Power-on and combined stretches count oscillator cycles.
// - Clock generation reset releases on an oscillator falling edge.
// - Peripheral and processor resets release on system falling edge.
// - Test logic reset comes from power-on reset alone.
// - A software reset request asserts a software reset; one made while sync logic reset still holds is dropped.
// - This block raises no interrupt requests.
`timescale 1ns/100ps
module ssrs_sequencer #(
  parameter int unsigned OSC_DIV = ssrs_pkg::OSC_DIV_DEF,
  parameter int unsigned SYS_DIV = ssrs_pkg::SYS_DIV_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous reset pins, active low
  input wire logic por_n,
  input wire logic ext_reset_n,
  // synchronous reset sources, same clock
  input wire logic sw_reset_req,
  input wire logic watchdog_timeout_reset,
  input wire logic watchdog_clock_loss_reset,
  // time bases
  output logic oscillator_tick,
  output logic system_tick,
  // staged resets
  output logic stretched_power_on_reset,
  output logic combined_reset,
  output logic sync_logic_reset,
  output logic control_enable,
  output logic clock_gen_reset,
  output logic clock_gen_run,
  output logic peripheral_reset_out,
  output logic processor_reset,
  output logic code_run,
  output logic jtag_reset
);
  import ssrs_pkg::*;

  localparam logic [DIV_W-1:0] OSC_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [DIV_W-1:0] OSC_HALF = DIV_W'(OSC_DIV / 2 - 1);
  localparam logic [DIV_W-1:0] SYS_LAST = DIV_W'(SYS_DIV - 1);
  localparam logic [DIV_W-1:0] SYS_HALF = DIV_W'(SYS_DIV / 2 - 1);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (OSC_DIV < 2 || OSC_DIV > DIV_MAX || OSC_DIV % 2 != 0)
  begin : g_bad_osc
    $error("oscillator divider must be even, 2 to 256");
  end
  if (SYS_DIV < 2 || SYS_DIV > DIV_MAX || SYS_DIV % 2 != 0)
  begin : g_bad_sys
    $error("system divider must be even, 2 to 256");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [SYNC_DEPTH-1:0] por_sync_q;
  logic [SYNC_DEPTH-1:0] ext_sync_q;
  logic por_act_q;
  logic ext_act_q;
  logic sw_rst_q;
  logic wd_rst_q;
  logic combined_q;
  logic control_en_q;
  logic jtag_rst_q;
  logic code_run_q;
  logic [DIV_W-1:0] osc_cnt_q;
  logic [DIV_W-1:0] sys_cnt_q;
  logic osc_fall_q;
  logic sys_fall_q;
  logic stretched_q;
  logic sync_rst_q;
  logic clock_gen_reset_q;
  logic periph_rst_q;
  logic core_rst_q;
  logic combined_d;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // three flops; the first feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_sync_q <= SYNC_RST;
      ext_sync_q <= SYNC_RST;
    end else begin
      por_sync_q <= {por_sync_q[1:0], por_n};
      ext_sync_q <= {ext_sync_q[1:0], ext_reset_n};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_act_q <= 1'b1;
    end else if (por_sync_q[1] == por_sync_q[2]) begin
      por_act_q <= ~por_sync_q[2];
    end
  end

  // external pin filtered the same way, held active from reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_act_q <= 1'b1;
    end else if (ext_sync_q[1] == ext_sync_q[2]) begin
      ext_act_q <= ~ext_sync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // oscillator time base
  // ---------------------------------------------------------------
  // free running; the oscillator never stops while powered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_cnt_q <= DIV_RST;
    end else if (osc_cnt_q == OSC_LAST) begin
      osc_cnt_q <= DIV_RST;
    end else begin
      osc_cnt_q <= osc_cnt_q + DIV_W'(1);
    end
  end

  // falling edge marks the mid point of each oscillator period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_fall_q <= 1'b0;
    end else begin
      osc_fall_q <= (osc_cnt_q == OSC_HALF);
    end
  end

  // ---------------------------------------------------------------
  // system clock time base
  // ---------------------------------------------------------------
  // the system clock stands still while clock generation is reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_cnt_q <= DIV_RST;
    end else if (clock_gen_reset_q) begin
      sys_cnt_q <= DIV_RST;
    end else if (sys_cnt_q == SYS_LAST) begin
      sys_cnt_q <= DIV_RST;
    end else begin
      sys_cnt_q <= sys_cnt_q + DIV_W'(1);
    end
  end

  // delayed system clock falling edge pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_fall_q <= 1'b0;
    end else begin
      sys_fall_q <= ~clock_gen_reset_q && (sys_cnt_q == SYS_HALF);
    end
  end

  // ---------------------------------------------------------------
  // power-on stretcher, outside combined reset like the test logic reset
  // ---------------------------------------------------------------
  ssrs_extender #(
    .COUNT(POR_STRETCH_TICKS)
  ) u_por_stretch (
    .clk(clk),
    .rst(rst),
    .hold(por_act_q),
    .tick(osc_fall_q),
    .rst_out_q(stretched_q)
  );

  // ---------------------------------------------------------------
  // synchronous reset sources
  // ---------------------------------------------------------------
  // requests are ignored while their own logic is held in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_rst_q <= 1'b0;
    end else if (sw_reset_req && !sync_rst_q) begin
      sw_rst_q <= 1'b1;
    end else if (sync_rst_q) begin
      sw_rst_q <= 1'b0;
    end
  end

  // both watchdog causes share one reset flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_rst_q <= 1'b0;
    end else if ((watchdog_timeout_reset || watchdog_clock_loss_reset)
                 && !sync_rst_q) begin
      wd_rst_q <= 1'b1;
    end else if (sync_rst_q) begin
      wd_rst_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // combined reset
  // ---------------------------------------------------------------
  always_comb begin
    combined_d = stretched_q | ext_act_q | sw_rst_q | wd_rst_q;
  end

  // registered so every stage sees one glitch free level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      combined_q <= 1'b1;
    end else begin
      combined_q <= combined_d;
    end
  end

  // control logic enabled only after combined release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_en_q <= 1'b0;
    end else begin
      control_en_q <= ~combined_q;
    end
  end

  // ---------------------------------------------------------------
  // oscillator timed stages
  // ---------------------------------------------------------------
  // software and watchdog logic reset, a short minimum pulse
  ssrs_extender #(
    .COUNT(SYNC_LOGIC_TICKS)
  ) u_sync_rst (
    .clk(clk),
    .rst(rst),
    .hold(combined_q),
    .tick(osc_fall_q),
    .rst_out_q(sync_rst_q)
  );

  // clock generation reset, released on oscillator falling edge
  ssrs_extender #(
    .COUNT(CLKGEN_TICKS)
  ) u_clock_gen_reset (
    .clk(clk),
    .rst(rst),
    .hold(combined_q),
    .tick(osc_fall_q),
    .rst_out_q(clock_gen_reset_q)
  );

  // ---------------------------------------------------------------
  // system clock timed stages
  // ---------------------------------------------------------------
  // peripherals stay clocked but reset for synchronous resolution
  ssrs_extender #(
    .COUNT(PERIPH_TICKS)
  ) u_periph_rst (
    .clk(clk),
    .rst(rst),
    .hold(clock_gen_reset_q),
    .tick(sys_fall_q),
    .rst_out_q(periph_rst_q)
  );

  // processor waits for peripheral set-up such as flash
  ssrs_extender #(
    .COUNT(CORE_TICKS)
  ) u_core_rst (
    .clk(clk),
    .rst(rst),
    .hold(periph_rst_q),
    .tick(sys_fall_q),
    .rst_out_q(core_rst_q)
  );

  // ---------------------------------------------------------------
  // code start and test logic reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_run_q <= 1'b0;
    end else begin
      code_run_q <= ~core_rst_q;
    end
  end

  // test logic ignores pin, software and watchdog resets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jtag_rst_q <= 1'b1;
    end else begin
      jtag_rst_q <= por_act_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs; no interrupt output exists at all
  // ---------------------------------------------------------------
  assign oscillator_tick = osc_fall_q;
  assign system_tick = sys_fall_q;
  assign stretched_power_on_reset = stretched_q;
  assign combined_reset = combined_q;
  assign sync_logic_reset = sync_rst_q;
  assign control_enable = control_en_q;
  assign clock_gen_reset = clock_gen_reset_q;
  assign clock_gen_run = ~clock_gen_reset_q;
  assign peripheral_reset_out = periph_rst_q;
  assign processor_reset = core_rst_q;
  assign code_run = code_run_q;
  assign jtag_reset = jtag_rst_q;

  // ---------------------------------------------------------------
  // helper for the system stage count check
  // ---------------------------------------------------------------
  logic [5:0] sys_ticks_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_ticks_q <= 6'h00;
    end else if (clock_gen_reset_q) begin
      sys_ticks_q <= 6'h00;
    end else if (sys_fall_q && sys_ticks_q != 6'h3F) begin
      sys_ticks_q <= sys_ticks_q + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  por_stretch_a: assert property (@(posedge clk) disable iff (rst)
    por_act_q |=> stretched_q)
    else $error("stretched power-on reset not held");

  combined_or_a: assert property (@(posedge clk) disable iff (rst)
    (stretched_q || ext_act_q || sw_rst_q || wd_rst_q) |=> combined_q)
    else $error("combined reset missed a source");

  ctrl_enable_a: assert property (@(posedge clk) disable iff (rst)
    control_en_q |-> $past(!combined_q))
    else $error("control enabled during combined reset");

  sync_release_a: assert property (@(posedge clk) disable iff (rst)
    $fell(sync_rst_q) |-> $past(osc_fall_q) && !combined_q)
    else $error("sync logic reset released off edge");

  clkgen_order_a: assert property (@(posedge clk) disable iff (rst)
    !clock_gen_reset_q |-> !$past(combined_q) && !$past(stretched_q, 2))
    else $error("clock generation released too early");

  clkgen_edge_a: assert property (@(posedge clk) disable iff (rst)
    $fell(clock_gen_reset_q) |-> $past(osc_fall_q))
    else $error("clock generation release off falling edge");

  sys_stopped_a: assert property (@(posedge clk) disable iff (rst)
    clock_gen_reset_q |=> !sys_fall_q)
    else $error("system clock ran under clock generation reset");

  periph_count_a: assert property (@(posedge clk) disable iff (rst)
    $fell(periph_rst_q) |-> $past(sys_ticks_q) == 6'd31
      && $past(sys_fall_q))
    else $error("peripheral reset released at wrong count");

  core_order_a: assert property (@(posedge clk) disable iff (rst)
    !core_rst_q |-> !$past(periph_rst_q) && $past(sys_ticks_q) >= 6'd33)
    else $error("processor reset released too early");

  core_edge_a: assert property (@(posedge clk) disable iff (rst)
    $fell(core_rst_q) |-> $past(sys_fall_q))
    else $error("processor release off falling edge");

  jtag_por_a: assert property (@(posedge clk) disable iff (rst)
    $rose(jtag_rst_q) |-> $past(por_act_q, 1))
    else $error("test logic reset from a non power-on source");

  restart_a: assert property (@(posedge clk) disable iff (rst)
    combined_q |=> clock_gen_reset_q ##1 periph_rst_q ##1 core_rst_q)
    else $error("sequence not restarted on reassertion");

endmodule : ssrs_sequencer

//--- dv/ssrs_far_model.sv
// far side model: clock generator, peripherals and core watching resets
`timescale 1ns/100ps
module ssrs_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // resets and time bases from the sequencer
  input wire logic por_n,
  input wire logic oscillator_tick,
  input wire logic system_tick,
  input wire logic stretched_power_on_reset,
  input wire logic combined_reset,
  input wire logic sync_logic_reset,
  input wire logic clock_gen_reset,
  input wire logic peripheral_reset_out,
  input wire logic processor_reset,
  // ticks each stage waited, and a sticky order fault
  output logic [7:0] n_por_q,
  output logic [7:0] n_sync_q,
  output logic [7:0] n_cg_q,
  output logic [7:0] n_per_q,
  output logic [7:0] n_core_q,
  output logic order_err_q
);
  logic cg_q;
  logic per_q;
  logic core_q;

  // restart on upstream reassertion, count ticks while held, then freeze
  function automatic logic [7:0] step(input logic [7:0] c, input logic up,
                                      input logic down, input logic t);
    if (up) begin
      return 8'h00;
    end
    return (down && t) ? c + 8'h01 : c;
  endfunction : step

  // stage counters; the stretch stages are timed on oscillator ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_por_q <= 8'h00;
      n_sync_q <= 8'h00;
      n_cg_q <= 8'h00;
      n_per_q <= 8'h00;
      n_core_q <= 8'h00;
    end else begin
      n_por_q <= step(n_por_q, !por_n, stretched_power_on_reset,
                      oscillator_tick);
      n_sync_q <= step(n_sync_q, combined_reset, sync_logic_reset,
                       oscillator_tick);
      n_cg_q <= step(n_cg_q, combined_reset, clock_gen_reset,
                     oscillator_tick);
      n_per_q <= step(n_per_q, clock_gen_reset, peripheral_reset_out,
                      system_tick);
      n_core_q <= step(n_core_q, peripheral_reset_out, processor_reset,
                       system_tick);
    end
  end

  // a stage let go while its upstream still holds breaks the order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cg_q <= 1'b1;
      per_q <= 1'b1;
      core_q <= 1'b1;
      order_err_q <= 1'b0;
    end else begin
      cg_q <= clock_gen_reset;
      per_q <= peripheral_reset_out;
      core_q <= processor_reset;
      if ((cg_q && !clock_gen_reset && combined_reset) ||
          (per_q && !peripheral_reset_out && clock_gen_reset) ||
          (core_q && !processor_reset && peripheral_reset_out)) begin
        order_err_q <= 1'b1;
      end
    end
  end
endmodule : ssrs_far_model

//--- dv/tb.sv
// testbench: staged reset release sequencer against the far side model
`timescale 1ns/100ps
module tb;
  import ssrs_pkg::*;
  logic clk, rst, por_n, ext_reset_n, sw_reset_req;
  logic watchdog_timeout_reset, watchdog_clock_loss_reset;
  logic oscillator_tick, system_tick, stretched_power_on_reset;
  logic combined_reset, sync_logic_reset, control_enable, clock_gen_reset;
  logic clock_gen_run, peripheral_reset_out, processor_reset, code_run;
  logic jtag_reset, order_err;
  logic [7:0] n_por, n_sync, n_cg, n_per, n_core;
  int n_fail = 0;
  int compares = 0;

  // -------------------------------------------------------------
  // design and far side
  // -------------------------------------------------------------
  // small dividers keep each release sequence to a few hundred cycles;
  // an oscillator period above the pin filter delay keeps raw-pin counts
  ssrs_sequencer #(.OSC_DIV(8), .SYS_DIV(2)) ssrs_sequencer_i (
    .clk(clk), .rst(rst), .por_n(por_n), .ext_reset_n(ext_reset_n),
    .sw_reset_req(sw_reset_req),
    .watchdog_timeout_reset(watchdog_timeout_reset),
    .watchdog_clock_loss_reset(watchdog_clock_loss_reset),
    .oscillator_tick(oscillator_tick), .system_tick(system_tick),
    .stretched_power_on_reset(stretched_power_on_reset),
    .combined_reset(combined_reset), .sync_logic_reset(sync_logic_reset),
    .control_enable(control_enable), .clock_gen_reset(clock_gen_reset),
    .clock_gen_run(clock_gen_run),
    .peripheral_reset_out(peripheral_reset_out),
    .processor_reset(processor_reset), .code_run(code_run),
    .jtag_reset(jtag_reset));

  ssrs_far_model ssrs_far_model_i (
    .clk(clk), .rst(rst), .por_n(por_n), .oscillator_tick(oscillator_tick),
    .system_tick(system_tick),
    .stretched_power_on_reset(stretched_power_on_reset),
    .combined_reset(combined_reset), .sync_logic_reset(sync_logic_reset),
    .clock_gen_reset(clock_gen_reset),
    .peripheral_reset_out(peripheral_reset_out),
    .processor_reset(processor_reset), .n_por_q(n_por), .n_sync_q(n_sync),
    .n_cg_q(n_cg), .n_per_q(n_per), .n_core_q(n_core),
    .order_err_q(order_err));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic test_done;
    $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // pick a watched output by number for the bounded wait
  function automatic logic sel(input int w);
    case (w)
      0: return combined_reset;
      1: return clock_gen_reset;
      2: return processor_reset;
      default: return stretched_power_on_reset;
    endcase
  endfunction : sel

  task automatic wait_until(input int w, input logic lvl, input int lim);
    int i;
    i = 0;
    @(negedge clk);
    while (sel(w) !== lvl && i < lim) begin
      @(negedge clk);
      i++;
    end
    if (sel(w) !== lvl) begin
      n_fail++;
      $display("ERROR at %0t: wait ran out", $time);
      test_done();
    end
  endtask : wait_until

  // source 0 software, 1 and 2 watchdog, other values the reset pin
  task automatic pulse(input int s, input int len);
    @(posedge clk);
    case (s)
      0: sw_reset_req <= 1'b1;
      1: watchdog_timeout_reset <= 1'b1;
      2: watchdog_clock_loss_reset <= 1'b1;
      default: ext_reset_n <= 1'b0;
    endcase
    repeat (len) @(posedge clk);
    sw_reset_req <= 1'b0;
    watchdog_timeout_reset <= 1'b0;
    watchdog_clock_loss_reset <= 1'b0;
    ext_reset_n <= 1'b1;
  endtask : pulse

  // whole release chain must finish with the stage counts exact
  task automatic check_seq;
    wait_until(2, 1'b0, 2000);
    @(negedge clk);
    check(n_sync, 32'(SYNC_LOGIC_TICKS));
    check(n_cg, 32'(CLKGEN_TICKS));
    check(n_per, 32'(PERIPH_TICKS));
    check(n_core, 32'(CORE_TICKS));
    check(order_err, 0);
    check(code_run, 1);
    check(clock_gen_run, 1);
    check(control_enable, 1);
    check(combined_reset, 0);
  endtask : check_seq

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_power_on;
    int i;
    repeat (12) @(negedge clk);
    check(stretched_power_on_reset, 1);
    check(jtag_reset, 1);
    check(code_run, 0);
    i = 0;
    // release right after a tick so the count has a clean start
    while (oscillator_tick !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
    por_n <= 1'b1;
    wait_until(3, 1'b0, 1000);
    check(n_por, 32'(POR_STRETCH_TICKS));
    check(jtag_reset, 0);
    check_seq();
    $display("test power_on done");
  endtask : t_power_on

  task automatic t_ext_pin;
    pulse(3, 10);
    @(negedge clk);
    check(combined_reset, 1);
    check(processor_reset, 1);
    check(stretched_power_on_reset, 0);
    check(jtag_reset, 0);
    check_seq();
    $display("test ext_pin done");
  endtask : t_ext_pin

  task automatic t_sync_sources;
    for (int s = 0; s < 3; s++) begin
      pulse(s, 1);
      wait_until(0, 1'b1, 8);
      check(jtag_reset, 0);
      wait_until(2, 1'b1, 8);
      check_seq();
    end
    $display("test sync_sources done");
  endtask : t_sync_sources

  task automatic t_restart;
    pulse(3, 6);
    wait_until(1, 1'b0, 2000);
    check(processor_reset, 1);
    pulse(3, 6);
    @(negedge clk);
    check(clock_gen_reset, 1);
    check_seq();
    $display("test restart done");
  endtask : t_restart

  // a request while the request logic is still held must be dropped
  task automatic t_refused;
    logic bad;
    bad = 1'b0;
    pulse(3, 6);
    wait_until(0, 1'b0, 100);
    check(sync_logic_reset, 1);
    pulse(0, 1);
    repeat (20) begin
      @(negedge clk);
      bad = bad | combined_reset;
    end
    check(bad, 0);
    check_seq();
    $display("test refused done");
  endtask : t_refused

  // power-on reasserted late must reset test logic and restart all
  task automatic t_por_again;
    @(posedge clk);
    por_n <= 1'b0;
    t_power_on();
    $display("test por_again done");
  endtask : t_por_again

  // -------------------------------------------------------------
  // clock and main sequence
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    por_n = 1'b0;
    ext_reset_n = 1'b1;
    sw_reset_req = 1'b0;
    watchdog_timeout_reset = 1'b0;
    watchdog_clock_loss_reset = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_power_on();
    t_ext_pin();
    t_sync_sources();
    t_restart();
    t_refused();
    t_por_again();
    test_done();
  end
endmodule : tb
